// ### src/dpr_consts.svh
// Constants for the dock power-role and multiplexer GPIO control block
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH

// ****************************************
// Pin field
// ****************************************
`define DPR_NGPIO 16
`define DPR_IDXW 4
`define DPR_GPIO_ZERO 16'h0000
`define DPR_GPIO_ONE 16'h0001

// ****************************************
// Reset values
// ****************************************
`define DPR_IDX_RST 4'h0
`define DPR_BYTE_RST 8'h00
`define DPR_SYNC_RST 16'h0000
`define DPR_SNAP_RST 9'h000

// ****************************************
// Source offers
// ****************************************
`define DPR_PDO_ALL 4'hF
`define DPR_PDO_5V_ONLY 4'h1
`define DPR_PDO_NONE 4'h0

`endif

// ### src/dpr_pkg.sv
// Types shared by the dock power-role control modules
package dpr_pkg;

  // ****************************************
  // Contract voltage codes
  // ****************************************
  typedef enum logic [1:0] {
    DPR_V5 = 2'b00,
    DPR_V9 = 2'b01,
    DPR_V15 = 2'b10,
    DPR_V20 = 2'b11
  } dpr_volt_t;

  // ****************************************
  // Power role states
  // ****************************************
  typedef enum logic [2:0] {
    DPR_ST_IDLE = 3'b000,
    DPR_ST_SRC_TRY = 3'b001,
    DPR_ST_SINK_BOOT = 3'b010,
    DPR_ST_SINK = 3'b011,
    DPR_ST_SWAP = 3'b100,
    DPR_ST_SOURCE = 3'b101
  } dpr_state_t;

endpackage : dpr_pkg

// ### src/dpr_mux_if.sv
// Multiplexer events and pin assignments passed from control to the pin router
`timescale 1ns/1ps
interface dpr_mux_if;
  logic alt_four;
  logic mux_en;
  logic flip;
  logic [3:0] idx_lane_mapping_select;
  logic [3:0] idx_muxen;
  logic [3:0] idx_orient;
  logic [3:0] idx_barrel;

  modport ctrl (
    output alt_four,
    output mux_en,
    output flip,
    output idx_lane_mapping_select,
    output idx_muxen,
    output idx_orient,
    output idx_barrel
  );

  modport router (
    input alt_four,
    input mux_en,
    input flip,
    input idx_lane_mapping_select,
    input idx_muxen,
    input idx_orient,
    input idx_barrel
  );
endinterface : dpr_mux_if

// ### src/dpr_pin_router.sv
// Routes multiplexer events onto configurable general-purpose pins
`timescale 1ns/1ps
`include "dpr_consts.svh"
module dpr_pin_router (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Events and assignments
  dpr_mux_if.router m,
  // Pins
  output logic [15:0] o_gpio_out,
  output logic [15:0] o_gpio_oe
);
  import dpr_pkg::*;

  logic [15:0] nxt_out;
  logic [15:0] nxt_oe;

  function automatic logic [15:0] dpr_onehot(input logic [3:0] idx);
    dpr_onehot = `DPR_GPIO_ONE << idx;
  endfunction : dpr_onehot

  // If firmware maps two events to one pin, the pin goes high when either event is high
  always_comb begin
    nxt_out = `DPR_GPIO_ZERO;
    nxt_oe = `DPR_GPIO_ZERO;
    nxt_oe = nxt_oe | dpr_onehot(m.idx_lane_mapping_select);
    if (m.alt_four) begin
      nxt_out = nxt_out | dpr_onehot(m.idx_lane_mapping_select);
    end
    nxt_oe = nxt_oe | dpr_onehot(m.idx_muxen);
    if (m.mux_en) begin
      nxt_out = nxt_out | dpr_onehot(m.idx_muxen);
    end
    nxt_oe = nxt_oe | dpr_onehot(m.idx_orient);
    if (m.flip) begin
      nxt_out = nxt_out | dpr_onehot(m.idx_orient);
    end
    // The sense pin must never be driven, even if it collides with an event
    nxt_oe = nxt_oe & ~dpr_onehot(m.idx_barrel);
    nxt_out = nxt_out & ~dpr_onehot(m.idx_barrel);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_gpio_out <= `DPR_GPIO_ZERO;
      o_gpio_oe <= `DPR_GPIO_ZERO;
    end else begin
      o_gpio_out <= nxt_out;
      o_gpio_oe <= nxt_oe;
    end
  end
endmodule : dpr_pin_router

// ### src/dpr_ctrl.sv
// Dock power-role, regulator and multiplexer GPIO control, top level
// Behaviour
// - Supply seen before any partner: attempt the source role automatically.
// - No supply, source attached first: boot from VBUS, power flash, optional sink path.
// - Supply appearing during a contract: enable source offers and request a role swap.
// - Set multiplexer lanes from sensed orientation and the chosen alternate mode.
// - Drive lane mapping select: four-lane video or two-lane video plus USB.
// - Drive multiplexer enable and a separate cable orientation output.
// - Multiplexer events are mapped to any general-purpose pin except the supply detect pin by configuration.
// - Supply detect arrives on a configured general-purpose pin used as input.
// - While supply present: no sink requests, offer source contracts 5 to 20 V.
// - Supply removed: leave any 20 V source contract, renegotiate as sink.
// - Supply returns: send updated source capabilities and renegotiate.
// - Regulator enable follows the plug event, asserting on every plug.
// - High-voltage source contract raises exactly one select: 9 V, 15 V or 20 V.
// - Assert the interrupt output when supply, plug, role state, contract, voltage or mux enable changes.
// - Firmware written by the controller is stored into the external flash.
`timescale 1ns/1ps
`include "dpr_consts.svh"
module dpr_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // General-purpose pins
  input wire logic [15:0] i_gpio_pin,
  output logic [15:0] o_gpio_out,
  output logic [15:0] o_gpio_oe,
  // Pin assignment and options from the system controller
  input wire logic [3:0] i_cfg_barrel_idx,
  input wire logic [3:0] i_cfg_lane_mapping_select_idx,
  input wire logic [3:0] i_cfg_muxen_idx,
  input wire logic [3:0] i_cfg_orient_idx,
  input wire logic i_cfg_sink_path_en,
  // Type-C and PD engine status
  input wire logic i_plug_attached,
  input wire logic i_partner_source,
  input wire logic i_orient_valid,
  input wire logic i_orient_flip,
  input wire logic i_alt_mode_valid,
  input wire logic i_alt_four_lane,
  input wire logic i_contract_valid,
  input wire dpr_pkg::dpr_volt_t i_contract_volt,
  input wire logic i_swap_done,
  // Requests to the PD engine
  output logic o_req_source_role,
  output logic o_sink_request_en,
  output logic [3:0] o_src_pdo_mask,
  output logic o_swap_req,
  output logic o_src_caps_send,
  output logic o_exit_contract,
  output logic o_ext_sink_path_en,
  output logic o_is_source,
  // Regulator control
  output logic o_regulator_enable_out,
  output logic o_volt_select_9v_out,
  output logic o_volt_select_15v_out,
  output logic o_volt_select_20v_out,
  // Interrupt toward the system controller
  input wire logic i_irq_ack,
  output logic o_irq_n,
  // Firmware path to external flash
  input wire logic i_fw_valid,
  input wire logic [7:0] i_fw_byte,
  output logic o_flash_power_en,
  output logic o_flash_wr_valid,
  output logic [7:0] o_flash_wr_byte
);
  import dpr_pkg::*;

  // ****************************************
  // Supply detect synchroniser
  // ****************************************
  logic [15:0] pin_s1_ff;
  logic [15:0] pin_s2_ff;
  logic [15:0] pin_s3_ff;
  logic barrel_ff;
  logic barrel_d_ff;
  logic barrel_rise;
  logic barrel_fall;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_s1_ff <= `DPR_SYNC_RST;
      pin_s2_ff <= `DPR_SYNC_RST;
      pin_s3_ff <= `DPR_SYNC_RST;
    end else begin
      pin_s1_ff <= i_gpio_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end
  // A level counts only once the last two stages agree
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      barrel_ff <= 1'b0;
      barrel_d_ff <= 1'b0;
    end else begin
      if (pin_s2_ff[i_cfg_barrel_idx] == pin_s3_ff[i_cfg_barrel_idx]) begin
        barrel_ff <= pin_s3_ff[i_cfg_barrel_idx];
      end
      barrel_d_ff <= barrel_ff;
    end
  end

  assign barrel_rise = barrel_ff & ~barrel_d_ff;
  assign barrel_fall = ~barrel_ff & barrel_d_ff;

  // ****************************************
  // Power role state machine
  // ****************************************
  dpr_state_t state_ff;
  dpr_state_t nxt_state;
  logic nxt_swap;
  logic nxt_exit;
  dpr_volt_t volt_ff;
  always_comb begin
    nxt_state = state_ff;
    nxt_swap = 1'b0;
    nxt_exit = 1'b0;
    unique case (state_ff)
      DPR_ST_IDLE: begin
        if (i_plug_attached && barrel_ff) begin
          nxt_state = DPR_ST_SRC_TRY;
        end else if (i_plug_attached && i_partner_source) begin
          nxt_state = DPR_ST_SINK_BOOT;
        end
      end
      DPR_ST_SRC_TRY: begin
        if (!i_plug_attached) begin
          nxt_state = DPR_ST_IDLE;
        end else if (!barrel_ff) begin
          nxt_state = DPR_ST_SINK_BOOT;
        end else if (i_contract_valid) begin
          nxt_state = DPR_ST_SOURCE;
        end
      end
      DPR_ST_SINK_BOOT: begin
        if (!i_plug_attached) begin
          nxt_state = DPR_ST_IDLE;
        end else if (i_contract_valid && barrel_ff) begin
          nxt_state = DPR_ST_SWAP;
          nxt_swap = 1'b1;
        end else if (i_contract_valid) begin
          nxt_state = DPR_ST_SINK;
        end
      end
      DPR_ST_SINK: begin
        if (!i_plug_attached) begin
          nxt_state = DPR_ST_IDLE;
        end else if (barrel_ff) begin
          nxt_state = DPR_ST_SWAP;
          nxt_swap = 1'b1;
        end
      end
      DPR_ST_SWAP: begin
        if (!i_plug_attached) begin
          nxt_state = DPR_ST_IDLE;
        end else if (!barrel_ff) begin
          nxt_state = DPR_ST_SINK;
        end else if (i_swap_done) begin
          nxt_state = DPR_ST_SOURCE;
        end
      end
      DPR_ST_SOURCE: begin
        if (!i_plug_attached) begin
          nxt_state = DPR_ST_IDLE;
        end else if (!barrel_ff) begin
          nxt_state = DPR_ST_SINK_BOOT;
          nxt_exit = (volt_ff == DPR_V20);
        end
      end
      default: begin
        nxt_state = DPR_ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= DPR_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // PD engine requests
  // ****************************************
  logic is_source;
  assign is_source = (state_ff == DPR_ST_SOURCE);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_req_source_role <= 1'b0;
      o_swap_req <= 1'b0;
      o_exit_contract <= 1'b0;
      o_src_caps_send <= 1'b0;
      o_is_source <= 1'b0;
    end else begin
      o_req_source_role <= (nxt_state == DPR_ST_SRC_TRY);
      o_swap_req <= nxt_swap;
      o_exit_contract <= nxt_exit | (barrel_fall & is_source);
      o_src_caps_send <= barrel_rise & i_plug_attached;
      o_is_source <= (nxt_state == DPR_ST_SOURCE);
    end
  end

  // Offers are gated by the supply, not the role, so a swap can present them early
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sink_request_en <= 1'b0;
      o_src_pdo_mask <= `DPR_PDO_NONE;
      o_ext_sink_path_en <= 1'b0;
    end else begin
      o_sink_request_en <= ~barrel_ff & i_plug_attached;
      o_src_pdo_mask <= barrel_ff ? `DPR_PDO_ALL : `DPR_PDO_5V_ONLY;
      o_ext_sink_path_en <= i_cfg_sink_path_en & ~barrel_ff & i_plug_attached &
                            ((state_ff == DPR_ST_SINK_BOOT) || (state_ff == DPR_ST_SINK));
    end
  end

  // ****************************************
  // Regulator enable and voltage selects
  // ****************************************
  logic hv_sel_en;
  assign hv_sel_en = i_plug_attached & is_source & i_contract_valid;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      volt_ff <= DPR_V5;
    end else if (!i_plug_attached || !i_contract_valid) begin
      volt_ff <= DPR_V5;
    end else begin
      volt_ff <= i_contract_volt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_regulator_enable_out <= 1'b0;
      o_volt_select_9v_out <= 1'b0;
      o_volt_select_15v_out <= 1'b0;
      o_volt_select_20v_out <= 1'b0;
    end else begin
      o_regulator_enable_out <= i_plug_attached;
      // Only one select may be high or the feedback network sums two taps
      o_volt_select_9v_out <= hv_sel_en & (i_contract_volt == DPR_V9);
      o_volt_select_15v_out <= hv_sel_en & (i_contract_volt == DPR_V15);
      o_volt_select_20v_out <= hv_sel_en & (i_contract_volt == DPR_V20);
    end
  end

  // ****************************************
  // Multiplexer control
  // ****************************************
  logic alt_four_ff;
  logic mux_en_ff;
  logic flip_ff;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mux_en_ff <= 1'b0;
      flip_ff <= 1'b0;
      alt_four_ff <= 1'b0;
    end else begin
      mux_en_ff <= i_plug_attached & i_orient_valid;
      if (i_plug_attached && i_orient_valid) begin
        flip_ff <= i_orient_flip;
      end
      if (!i_plug_attached) begin
        alt_four_ff <= 1'b0;
      end else if (i_alt_mode_valid) begin
        alt_four_ff <= i_alt_four_lane;
      end
    end
  end

  dpr_mux_if mux_bus ();
  assign mux_bus.alt_four = alt_four_ff;
  assign mux_bus.mux_en = mux_en_ff;
  assign mux_bus.flip = flip_ff;
  assign mux_bus.idx_lane_mapping_select = i_cfg_lane_mapping_select_idx;
  assign mux_bus.idx_muxen = i_cfg_muxen_idx;
  assign mux_bus.idx_orient = i_cfg_orient_idx;
  assign mux_bus.idx_barrel = i_cfg_barrel_idx;
  dpr_pin_router u_router (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .m(mux_bus),
    .o_gpio_out(o_gpio_out),
    .o_gpio_oe(o_gpio_oe)
  );

  // ****************************************
  // Change interrupt
  // ****************************************
  logic [8:0] snap_ff;
  logic [8:0] snap_now;
  logic change;

  assign snap_now = {barrel_ff, i_plug_attached, state_ff, i_contract_valid, volt_ff,
                     mux_en_ff};
  assign change = (snap_now != snap_ff);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      snap_ff <= `DPR_SNAP_RST;
      o_irq_n <= 1'b1;
    end else begin
      snap_ff <= snap_now;
      // A change in the acknowledge cycle keeps the interrupt asserted
      if (change) begin
        o_irq_n <= 1'b0;
      end else if (i_irq_ack) begin
        o_irq_n <= 1'b1;
      end
    end
  end

  // ****************************************
  // Firmware store path
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_flash_power_en <= 1'b0;
      o_flash_wr_valid <= 1'b0;
      o_flash_wr_byte <= `DPR_BYTE_RST;
    end else begin
      // Flash stays powered so code can load even in no-battery boot
      o_flash_power_en <= 1'b1;
      o_flash_wr_valid <= i_fw_valid;
      if (i_fw_valid) begin
        o_flash_wr_byte <= i_fw_byte;
      end
    end
  end
endmodule : dpr_ctrl

// ### verif/dpr_board_model.sv
// Board model: barrel-jack detect comparator and pin pull-downs
`timescale 1ns/1ps
module dpr_board_model (
  // Board level
  input wire logic i_barrel_present,
  input wire logic [3:0] i_barrel_idx,
  // Controller pins
  input wire logic [15:0] i_gpio_out,
  input wire logic [15:0] i_gpio_oe,
  output logic [15:0] o_gpio_pin
);
  // ****
  // Pin levels
  // ****
  // Undriven pins sit on pull-downs, so a released pin never keeps its last value
  always_comb begin
    o_gpio_pin = i_gpio_out & i_gpio_oe;
    o_gpio_pin[i_barrel_idx] = i_barrel_present;
  end
endmodule : dpr_board_model

// ### verif/dpr_ctrl_assertions.sv
// Port-level checks for the dock power-role controller
`timescale 1ns/1ps
module dpr_ctrl_assertions (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Watched ports
  input wire logic [15:0] o_gpio_out,
  input wire logic [15:0] o_gpio_oe,
  input wire logic [3:0] i_cfg_barrel_idx,
  input wire logic [3:0] i_cfg_lane_mapping_select_idx,
  input wire logic [3:0] i_cfg_muxen_idx,
  input wire logic [3:0] i_cfg_orient_idx,
  input wire logic i_plug_attached,
  input wire logic i_orient_valid,
  input wire logic i_contract_valid,
  input wire dpr_pkg::dpr_volt_t i_contract_volt,
  input wire logic i_irq_ack,
  input wire logic i_fw_valid,
  input wire logic [7:0] i_fw_byte,
  input wire logic [3:0] o_src_pdo_mask,
  input wire logic o_sink_request_en,
  input wire logic o_swap_req,
  input wire logic o_src_caps_send,
  input wire logic o_exit_contract,
  input wire logic o_is_source,
  input wire logic o_regulator_enable_out,
  input wire logic o_volt_select_9v_out,
  input wire logic o_volt_select_15v_out,
  input wire logic o_volt_select_20v_out,
  input wire logic o_irq_n,
  input wire logic o_flash_wr_valid,
  input wire logic [7:0] o_flash_wr_byte
);
  import dpr_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic [2:0] sel;
  assign sel = {o_volt_select_9v_out, o_volt_select_15v_out, o_volt_select_20v_out};
  // ****
  // Sequences
  // ****
  sequence s_src_9v;
    (i_plug_attached && o_is_source && i_contract_valid && i_contract_volt == DPR_V9) [*3];
  endsequence
  sequence s_unplugged;
    (!i_plug_attached && $stable(i_cfg_muxen_idx) && i_cfg_muxen_idx != i_cfg_orient_idx
      && i_cfg_muxen_idx != i_cfg_lane_mapping_select_idx) [*3];
  endsequence
  sequence s_cable_on;
    (i_plug_attached && i_orient_valid && $stable(i_cfg_muxen_idx)
      && i_cfg_muxen_idx != i_cfg_barrel_idx) [*3];
  endsequence
  sequence s_sense_fixed;
    $stable(i_cfg_barrel_idx);
  endsequence
  sequence s_flash_copy;
    o_flash_wr_valid && o_flash_wr_byte == $past(i_fw_byte);
  endsequence
  // ****
  // Assertions
  // ****
  a_reg_follows_plug: assert property (i_plug_attached |=> o_regulator_enable_out)
    else $error("regulator enable missed a plug");
  a_reg_off_unplug: assert property (!i_plug_attached |=> !o_regulator_enable_out)
    else $error("regulator enabled without plug");
  a_volt_one_hot: assert property ($onehot0(sel))
    else $error("more than one voltage select high");
  a_volt_off_unplug: assert property (!i_plug_attached [*3] |-> sel == 3'b000)
    else $error("voltage select high without plug");
  a_volt_nine: assert property (s_src_9v |-> o_volt_select_9v_out)
    else $error("9 V select missing");
  a_no_sink_req: assert property (o_src_pdo_mask == 4'hF [*2] |-> !o_sink_request_en)
    else $error("sink request while supply present");
  a_detect_input: assert property (s_sense_fixed |-> !o_gpio_oe[i_cfg_barrel_idx])
    else $error("supply detect pin driven");
  a_mux_on: assert property (s_cable_on |-> o_gpio_out[i_cfg_muxen_idx])
    else $error("mux enable pin not high");
  a_mux_off: assert property (s_unplugged |-> !o_gpio_out[i_cfg_muxen_idx])
    else $error("mux enable pin high without cable");
  a_swap_with_caps: assert property (o_swap_req |-> o_src_caps_send ##1 !o_swap_req)
    else $error("swap request without capability send");
  a_exit_pulse: assert property (o_exit_contract |=> !o_exit_contract && !o_is_source)
    else $error("contract exit not a single pulse");
  a_irq_hold: assert property (!o_irq_n && !i_irq_ack |=> !o_irq_n)
    else $error("interrupt dropped without ack");
  a_irq_on_plug: assert property ($changed(i_plug_attached) |-> ##[1:3] !o_irq_n)
    else $error("no interrupt on plug change");
  a_flash_pass: assert property (i_fw_valid |=> s_flash_copy)
    else $error("firmware byte not passed to flash");
endmodule : dpr_ctrl_assertions

bind dpr_ctrl dpr_ctrl_assertions u_chk (.*);

// ### verif/tb_dpr_ctrl.sv
// Self-checking bench for the dock power-role controller
`timescale 1ns/1ps
module tb_dpr_ctrl;
  import dpr_pkg::*;
  typedef struct {dpr_volt_t v; logic [2:0] sel;} dpr_row_t;
  // ****
  // Signals
  // ****
  logic i_clk, i_rstn, barrel, i_cfg_sink_path_en, i_plug_attached, i_partner_source;
  logic i_orient_valid, i_orient_flip, i_alt_mode_valid, i_alt_four_lane, i_contract_valid;
  logic i_swap_done, i_irq_ack, i_fw_valid, o_req_source_role, o_sink_request_en, o_swap_req;
  logic o_src_caps_send, o_exit_contract, o_ext_sink_path_en, o_is_source, o_irq_n;
  logic o_regulator_enable_out, o_volt_select_9v_out, o_volt_select_15v_out;
  logic o_volt_select_20v_out, o_flash_power_en, o_flash_wr_valid;
  logic [15:0] i_gpio_pin, o_gpio_out, o_gpio_oe;
  logic [3:0] i_cfg_barrel_idx, i_cfg_lane_mapping_select_idx, i_cfg_muxen_idx, i_cfg_orient_idx;
  logic [3:0] o_src_pdo_mask;
  logic [7:0] i_fw_byte, o_flash_wr_byte;
  logic [2:0] sel;
  dpr_volt_t i_contract_volt;
  int fail_count, comparisons;
  dpr_row_t rows[4] = '{'{DPR_V9, 3'b100}, '{DPR_V15, 3'b010}, '{DPR_V20, 3'b001},
    '{DPR_V5, 3'b000}};
  assign sel = {o_volt_select_9v_out, o_volt_select_15v_out, o_volt_select_20v_out};
  dpr_ctrl uut (.*);
  dpr_board_model board (.i_barrel_present(barrel), .i_barrel_idx(i_cfg_barrel_idx),
    .i_gpio_out(o_gpio_out), .i_gpio_oe(o_gpio_oe), .o_gpio_pin(i_gpio_pin));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask : cyc
  // Bounded wait; a pulse is caught because every negedge is inspected
  task automatic wait_hi(input bit swap);
    int n;
    n = 0;
    while ((swap ? o_swap_req : o_exit_contract) !== 1'b1 && n < 10) begin
      @(negedge i_clk);
      n++;
    end
  endtask : wait_hi
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // Whole run is under 200 cycles, so 1000 leaves ample margin
  initial begin
    repeat (1000) @(posedge i_clk);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  // ****
  // Sequence
  // ****
  initial begin
    {i_rstn, barrel, i_cfg_sink_path_en, i_plug_attached, i_partner_source, i_orient_valid,
      i_orient_flip, i_alt_mode_valid, i_alt_four_lane, i_contract_valid, i_swap_done,
      i_irq_ack, i_fw_valid, i_fw_byte} = '0;
    i_contract_volt = DPR_V5;
    i_cfg_barrel_idx = 4'h2;
    i_cfg_lane_mapping_select_idx = 4'h0;
    i_cfg_muxen_idx = 4'h3;
    i_cfg_orient_idx = 4'h9;
    cyc(12);
    chk({o_irq_n, o_src_pdo_mask}, 5'h10, "reset values");
    i_rstn = 1'b1;
    cyc(1);
    chk({o_flash_power_en, o_src_pdo_mask}, 5'h11, "after reset");
    barrel = 1'b1;
    cyc(6);
    chk(o_src_pdo_mask, 4'hF, "offers with supply");
    i_plug_attached = 1'b1;
    cyc(2);
    chk({o_req_source_role, o_regulator_enable_out, o_sink_request_en}, 3'b110, "try");
    i_contract_valid = 1'b1;
    cyc(3);
    chk({o_is_source, o_req_source_role}, 2'b10, "source role");
    foreach (rows[r]) begin
      i_contract_volt = rows[r].v;
      cyc(4);
      chk(sel, rows[r].sel, "voltage select");
    end
    {i_orient_valid, i_orient_flip, i_alt_mode_valid, i_alt_four_lane} = 4'hF;
    cyc(3);
    chk(o_gpio_out & 16'h020D, 16'h0209, "mux pins");
    chk(o_gpio_oe & 16'h020D, 16'h0209, "mux pin drive");
    i_cfg_muxen_idx = 4'h7;
    cyc(3);
    chk(o_gpio_out & 16'h0088, 16'h0080, "mux remap");
    i_alt_four_lane = 1'b0;
    cyc(3);
    chk(o_gpio_out[0], 1'b0, "two-lane map");
    chk(o_irq_n, 1'b0, "irq raised");
    i_irq_ack = 1'b1;
    cyc(1);
    i_irq_ack = 1'b0;
    cyc(2);
    chk(o_irq_n, 1'b1, "irq cleared");
    {i_orient_valid, i_orient_flip} = 2'b00;
    cyc(3);
    chk(o_gpio_out & 16'h0280, 16'h0200, "flip held");
    i_contract_volt = DPR_V20;
    cyc(4);
    barrel = 1'b0;
    wait_hi(1'b0);
    chk(o_exit_contract, 1'b1, "exit pulse");
    cyc(2);
    chk({o_is_source, o_sink_request_en, sel}, 5'h08, "sink after exit");
    chk(o_irq_n, 1'b0, "irq on change");
    i_contract_valid = 1'b0;
    cyc(2);
    i_contract_valid = 1'b1;
    cyc(2);
    barrel = 1'b1;
    wait_hi(1'b1);
    chk(o_swap_req, 1'b1, "swap request");
    chk(o_src_caps_send, 1'b1, "capabilities sent");
    i_swap_done = 1'b1;
    cyc(1);
    i_swap_done = 1'b0;
    cyc(2);
    chk({o_is_source, o_src_pdo_mask}, 5'h1F, "source after swap");
    i_fw_valid = 1'b1;
    i_fw_byte = 8'hA5;
    cyc(1);
    i_fw_valid = 1'b0;
    chk({o_flash_wr_valid, o_flash_wr_byte}, 9'h1A5, "flash byte");
    i_plug_attached = 1'b0;
    cyc(4);
    chk({o_regulator_enable_out, sel, o_gpio_out[7]}, 5'h00, "unplugged");
    i_rstn = 1'b0;
    barrel = 1'b0;
    cyc(2);
    i_rstn = 1'b1;
    {i_plug_attached, i_partner_source, i_cfg_sink_path_en} = 3'b111;
    cyc(6);
    chk({o_sink_request_en, o_req_source_role, o_flash_power_en}, 3'b101, "vbus boot");
    chk(o_ext_sink_path_en, 1'b1, "sink path");
    tally_and_finish();
  end
endmodule : tb_dpr_ctrl
